/* File: msp_pkg.sv */
// Shared constants, carriers and state types of the meter serial port pins block
package msp_pkg;

    // ------------------------------------------------------------
    // Serial framing
    // ------------------------------------------------------------
    localparam int MSP_BYTE_W = 8;
    localparam int MSP_CMD_WRITE_BIT = 7;
    localparam logic [2:0] MSP_CNT_RST = 3'h0;
    localparam logic [2:0] MSP_CNT_LAST = 3'h7;
    localparam logic [7:0] MSP_BYTE_RST = 8'h00;
    localparam int MSP_FIFO_DEPTH = 4;
    localparam logic [1:0] MSP_CS_SYNC_RST = 2'h3;

    // ------------------------------------------------------------
    // Interrupt sources
    // ------------------------------------------------------------
    localparam int MSP_IRQ_W = 4;
    localparam int MSP_IRQ_ACT_HALF = 0;
    localparam int MSP_IRQ_APP_HALF = 1;
    localparam int MSP_IRQ_WAVE = 2;
    localparam int MSP_IRQ_SUPPLY = 3;
    localparam int MSP_WAVE_RATE_MAX_KSPS = 26;
    localparam logic [3:0] MSP_IRQ_ALWAYS_MASK = 4'h8;
    localparam logic [3:0] MSP_STATUS_RST = 4'h0;

    typedef logic [MSP_IRQ_W-1:0] msp_irq_t;

    // Received byte with frame position
    typedef struct packed {
        logic first;
        logic [MSP_BYTE_W-1:0] data;
    } msp_rx_t;

    // Falling edge logic, cleared when the frame ends
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [MSP_BYTE_W-2:0] shift;
        logic cmd_done;
        logic read_phase;
    } msp_fall_t;

    // Falling edge word handed to the core clock, cleared by device reset only
    typedef struct packed {
        msp_rx_t rx_word;
        logic rx_tgl;
    } msp_xfer_t;

    // Rising edge launch logic, cleared when the frame ends
    typedef struct packed {
        logic [MSP_BYTE_W-1:0] shift;
        logic oe;
    } msp_rise_t;

    // Core clock state
    typedef struct packed {
        logic run;
        logic [1:0] cs_sync;
        logic [1:0] rx_sync;
        logic rx_seen;
        logic [1:0] ack_sync;
        logic ack_seen;
        msp_rx_t pend;
        logic pend_v;
        logic overrun;
        logic [MSP_BYTE_W-1:0] tx_hold;
        logic tx_full;
        logic underrun;
        msp_irq_t status;
        logic irq;
    } msp_core_t;

    localparam msp_fall_t MSP_FALL_RST = '0;
    localparam msp_xfer_t MSP_XFER_RST = '0;
    localparam msp_rise_t MSP_RISE_RST = '0;
    localparam msp_core_t MSP_CORE_RST = '0;

endpackage

/* File: msp_fifo.sv */
// Parameterised valid/ready FIFO for received serial bytes
module msp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    output logic [WIDTH-1:0] o_data,
    output logic o_valid,
    input wire logic i_ready
);
    import msp_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } msp_fifo_state_t;

    msp_fifo_state_t st_q;
    msp_fifo_state_t st_d;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // Handshake and next state
    // ------------------------------------------------------------
    assign o_ready = (st_q.count != DEPTH_CNT);
    assign o_valid = (st_q.count != '0);
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wr_ptr] = i_data;
            st_d.wr_ptr = (st_q.wr_ptr == LAST_PTR) ? '0 : st_q.wr_ptr + 1'b1;
        end
        if (pop) begin
            st_d.rd_ptr = (st_q.rd_ptr == LAST_PTR) ? '0 : st_q.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            st_d.count = st_q.count + 1'b1;
        end else if (pop && !push) begin
            st_d.count = st_q.count - 1'b1;
        end
        if (!i_reset_n) begin
            st_d = '0;
        end
    end

    // Storage and pointers
    always_ff @(posedge i_clk) begin
        st_q <= st_d;
    end

    // Head word comes straight from the storage flops
    assign o_data = st_q.mem[st_q.rd_ptr];

endmodule

/* File: msp_top.sv */
// Pin-level serial port, interrupt request and reset of the meter device
module msp_top (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_din,
    output logic o_dout,
    output logic o_dout_oe,
    output logic o_irq_n_out,
    output logic o_irq_n_oe,
    output msp_pkg::msp_rx_t o_rx_word,
    output logic o_rx_valid,
    input wire logic i_rx_ready,
    input wire logic [msp_pkg::MSP_BYTE_W-1:0] i_tx_data,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    input wire msp_pkg::msp_irq_t i_irq_event,
    input wire msp_pkg::msp_irq_t i_irq_enable,
    input wire msp_pkg::msp_irq_t i_irq_clear,
    output msp_pkg::msp_irq_t o_irq_status,
    output logic o_rx_overrun,
    output logic o_tx_underrun,
    output logic o_frame_active
);
    import msp_pkg::*;

    // i_clk is the master_clock_in of the device and runs the core side

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    msp_fall_t fall_q;
    msp_fall_t fall_d;
    msp_xfer_t xfer_q;
    msp_xfer_t xfer_d;
    msp_rise_t rise_q;
    msp_rise_t rise_d;
    logic ack_tgl_q;
    logic ack_tgl_d;
    msp_core_t core_q;
    msp_core_t core_d;
    logic link_rst_n;
    logic dev_rst_n;
    logic fifo_in_ready;
    logic rx_edge;
    logic ack_edge;

    // ------------------------------------------------------------
    // Link resets
    // ------------------------------------------------------------
    // Device reset clears the whole link side a core clock later; frame end clears only the frame and output state
    assign dev_rst_n = core_q.run;
    assign link_rst_n = !i_cs_n && core_q.run;

    // ------------------------------------------------------------
    // Falling edge: input capture
    // ------------------------------------------------------------
    // Shift one input bit per falling edge; the eighth completes a byte
    always_comb begin
        fall_d = fall_q;
        xfer_d = xfer_q;
        ack_tgl_d = ack_tgl_q;
        fall_d.bit_cnt = fall_q.bit_cnt + 3'h1;
        fall_d.shift = {fall_q.shift[MSP_BYTE_W-3:0], i_din};
        // First fall of a read byte confirms the host took the loaded word
        if (fall_q.read_phase && (fall_q.bit_cnt == MSP_CNT_RST)) begin
            ack_tgl_d = !ack_tgl_q;
        end
        if (fall_q.bit_cnt == MSP_CNT_LAST) begin
            xfer_d.rx_word.data = {fall_q.shift, i_din};
            xfer_d.rx_word.first = !fall_q.cmd_done;
            xfer_d.rx_tgl = !xfer_q.rx_tgl;
            fall_d.cmd_done = 1'b1;
            if (!fall_q.cmd_done) begin
                // Command top bit clear means the host reads back
                fall_d.read_phase = !fall_q.shift[MSP_CMD_WRITE_BIT-1];
            end
        end
    end

    // Frame state, cleared asynchronously by chip select going high
    always_ff @(negedge i_sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            fall_q <= MSP_FALL_RST;
        end else begin
            fall_q <= fall_d;
        end
    end

    // Handed-over byte survives frame end so the core can still take it
    always_ff @(negedge i_sclk or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            xfer_q <= MSP_XFER_RST;
        end else begin
            xfer_q <= xfer_d;
        end
    end

    // ------------------------------------------------------------
    // Rising edge: output launch
    // ------------------------------------------------------------
    // Load a fresh byte at each byte boundary of the read phase
    always_comb begin
        rise_d = rise_q;
        if (fall_q.read_phase) begin
            rise_d.oe = 1'b1;
            if (fall_q.bit_cnt == MSP_CNT_RST) begin
                rise_d.shift = core_q.tx_hold;
            end else begin
                rise_d.shift = {rise_q.shift[MSP_BYTE_W-2:0], 1'b0};
            end
        end
    end

    // Output driver state, released as soon as the frame ends
    always_ff @(posedge i_sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rise_q <= MSP_RISE_RST;
        end else begin
            rise_q <= rise_d;
        end
    end

    // Take-over toggle must not fall back at frame end or a false edge appears
    // Kept on the fall so the idle return of the clock after a frame takes nothing
    always_ff @(negedge i_sclk or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            ack_tgl_q <= 1'b0;
        end else begin
            ack_tgl_q <= ack_tgl_d;
        end
    end

    assign o_dout = rise_q.shift[MSP_BYTE_W-1];
    assign o_dout_oe = rise_q.oe;

    // ------------------------------------------------------------
    // Core clock side
    // ------------------------------------------------------------
    // Toggle edges are taken only from the second synchroniser stage
    assign rx_edge = core_q.rx_sync[1] ^ core_q.rx_seen;
    assign ack_edge = core_q.ack_sync[1] ^ core_q.ack_seen;

    // Crossings, receive hand-off, transmit holding word and interrupts
    always_comb begin
        core_d = core_q;
        core_d.run = 1'b1;
        core_d.cs_sync = {core_q.cs_sync[0], i_cs_n};
        core_d.rx_sync = {core_q.rx_sync[0], xfer_q.rx_tgl};
        core_d.rx_seen = core_q.rx_sync[1];
        core_d.ack_sync = {core_q.ack_sync[0], ack_tgl_q};
        core_d.ack_seen = core_q.ack_sync[1];
        // Pending byte drains into the FIFO; a full FIFO stalls it here
        if (core_q.pend_v && fifo_in_ready) begin
            core_d.pend_v = 1'b0;
        end
        if (rx_edge) begin
            if (core_q.pend_v && !fifo_in_ready) begin
                core_d.overrun = 1'b1;
            end else begin
                core_d.pend = xfer_q.rx_word;
                core_d.pend_v = 1'b1;
            end
        end
        // Link took the holding word; an empty one means stale data went out
        if (ack_edge) begin
            core_d.tx_full = 1'b0;
            if (!core_q.tx_full) begin
                core_d.underrun = 1'b1;
            end
        end
        if (i_tx_valid && !core_q.tx_full) begin
            core_d.tx_hold = i_tx_data;
            core_d.tx_full = 1'b1;
        end
        // Sticky status, an event beats a clear in the same cycle
        core_d.status = (core_q.status & ~i_irq_clear) | i_irq_event;
        core_d.irq = |(core_d.status & i_irq_enable & ~MSP_IRQ_ALWAYS_MASK);
        if (!i_reset_n) begin
            core_d = MSP_CORE_RST;
            core_d.cs_sync = MSP_CS_SYNC_RST; // Idle level, no false frame after reset
        end
    end

    // Core state register
    always_ff @(posedge i_clk) begin
        core_q <= core_d;
    end

    // Open-drain request: drive low only when a request stands
    assign o_irq_n_out = 1'b0;
    assign o_irq_n_oe = core_q.irq;

    assign o_irq_status = core_q.status;
    assign o_rx_overrun = core_q.overrun;
    assign o_tx_underrun = core_q.underrun;
    assign o_tx_ready = !core_q.tx_full;
    assign o_frame_active = !core_q.cs_sync[1];

    // ------------------------------------------------------------
    // Receive FIFO
    // ------------------------------------------------------------
    msp_fifo #(
        .WIDTH($bits(msp_rx_t)),
        .DEPTH(MSP_FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_data(core_q.pend),
        .i_valid(core_q.pend_v),
        .o_ready(fifo_in_ready),
        .o_data(o_rx_word),
        .o_valid(o_rx_valid),
        .i_ready(i_rx_ready)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Reset clears request, status and stream
    property p_reset_clears;
        @(posedge i_clk) !i_reset_n |=> !o_irq_n_oe && (o_irq_status == MSP_STATUS_RST)
            && !o_rx_valid && o_tx_ready && !dev_rst_n;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear");

    // Request stands exactly when an enabled, unmasked flag is set
    property p_irq_level;
        @(posedge i_clk) disable iff (!i_reset_n)
        $past(i_reset_n) |-> o_irq_n_oe ==
            (|(o_irq_status & $past(i_irq_enable) & ~MSP_IRQ_ALWAYS_MASK));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

    // A waveform event is kept even against a clear in the same cycle
    property p_event_sticky;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_irq_event[MSP_IRQ_WAVE] |=> o_irq_status[MSP_IRQ_WAVE] [*1]
            ##0 (o_irq_n_oe || !$past(i_irq_enable[MSP_IRQ_WAVE]));
    endproperty
    a_event_sticky: assert property (p_event_sticky) else $error("event lost");

    // Supply drop alone never raises the request
    property p_supply_masked;
        @(posedge i_clk) disable iff (!i_reset_n)
        $rose(o_irq_n_oe) |-> |(o_irq_status & $past(i_irq_enable) & ~MSP_IRQ_ALWAYS_MASK);
    endproperty
    a_supply_masked: assert property (p_supply_masked) else $error("supply flag raised irq");

    // A crossed byte reaches the pending slot with its captured value
    property p_rx_cross;
        @(posedge i_clk) disable iff (!i_reset_n)
        rx_edge && !(core_q.pend_v && !fifo_in_ready) |=>
            core_q.pend_v && (core_q.pend == $past(xfer_q.rx_word));
    endproperty
    a_rx_cross: assert property (p_rx_cross) else $error("byte not handed over");

    // Eighth falling edge stores the last input bit
    property p_sample_fall;
        @(negedge i_sclk) disable iff (!link_rst_n)
        fall_q.bit_cnt == MSP_CNT_LAST |=> xfer_q.rx_word.data[0] == $past(i_din);
    endproperty
    a_sample_fall: assert property (p_sample_fall) else $error("input bit not sampled");

    // Each rising edge inside a read byte presents the next bit
    property p_launch_rise;
        @(posedge i_sclk) disable iff (!link_rst_n)
        fall_q.read_phase && (fall_q.bit_cnt != MSP_CNT_RST) |=>
            o_dout == $past(rise_q.shift[MSP_BYTE_W-2]);
    endproperty
    a_launch_rise: assert property (p_launch_rise) else $error("output bit not launched");

    // Output is driven only in the read phase of a live frame
    property p_dout_hiz;
        @(posedge i_sclk) disable iff (!link_rst_n)
        o_dout_oe |-> fall_q.read_phase && fall_q.cmd_done;
    endproperty
    a_dout_hiz: assert property (p_dout_hiz) else $error("output driven outside read");

    // Deselect leaves the counter at frame start and the output released
    property p_deselect_abort;
        @(posedge i_clk) disable iff (!i_reset_n)
        core_q.cs_sync[1] && $past(core_q.cs_sync[1]) |-> (fall_q.bit_cnt == MSP_CNT_RST)
            && !fall_q.cmd_done && !o_dout_oe && !o_frame_active;
    endproperty
    a_deselect_abort: assert property (p_deselect_abort) else $error("frame not aborted");

    // Holding word accepted once, then ready stays low until the link takes it
    property p_tx_hold;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_tx_ready && i_tx_valid |=> !o_tx_ready;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("holding word overwritten");

    // The first fall of each read byte hands the holding word back to the core
    property p_ack_fall;
        @(negedge i_sclk) disable iff (!link_rst_n)
        fall_q.read_phase && (fall_q.bit_cnt == MSP_CNT_RST) |=>
            ack_tgl_q != $past(ack_tgl_q);
    endproperty
    a_ack_fall: assert property (p_ack_fall) else $error("holding word not taken");

    // A set and a clear of one flag in the same cycle leave the flag set
    property p_set_wins;
        @(posedge i_clk) disable iff (!i_reset_n)
        |(i_irq_event & i_irq_clear) |=>
            &(o_irq_status | ~($past(i_irq_event) & $past(i_irq_clear)));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a set");

    // Lost receive data stays flagged until the next device reset
    property p_overrun_sticky;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_rx_overrun |=> o_rx_overrun;
    endproperty
    a_overrun_sticky: assert property (p_overrun_sticky) else $error("overrun flag lost");

    // A stale byte sent stays flagged until the next device reset
    property p_underrun_sticky;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_tx_underrun |=> o_tx_underrun;
    endproperty
    a_underrun_sticky: assert property (p_underrun_sticky) else $error("underrun flag lost");

    // Main scenarios
    property p_cov_read;
        @(posedge i_sclk) $rose(o_dout_oe);
    endproperty
    c_cov_read: cover property (p_cov_read);

    property p_cov_rx;
        @(posedge i_clk) o_rx_valid && i_rx_ready && o_rx_word.first;
    endproperty
    c_cov_rx: cover property (p_cov_rx);

    property p_cov_irq;
        @(posedge i_clk) $rose(o_irq_n_oe);
    endproperty
    c_cov_irq: cover property (p_cov_irq);

    property p_cov_full;
        @(posedge i_clk) core_q.pend_v && !fifo_in_ready;
    endproperty
    c_cov_full: cover property (p_cov_full);

    property p_cov_underrun;
        @(posedge i_clk) $rose(o_tx_underrun);
    endproperty
    c_cov_underrun: cover property (p_cov_underrun);

endmodule

/* File: msp_host_model.sv */
// Host serial master model that drives the meter serial port pins
module msp_host_model (
    input wire logic i_dout,
    input wire logic i_dout_oe,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_din
);
    timeunit 1ns;
    timeprecision 100ps;

    logic last_bit = 1'b0;

    // Idle bus: clock high and stopped, device not selected
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_din = 1'b0;
    end

    // ------------------------------------------------------------
    // One frame of n bits, MSB first, 15 ns serial clock
    // ------------------------------------------------------------
    task automatic frame(input logic [47:0] tx, input int nbits, output logic [47:0] rx);
        logic seen;
        rx = '0;
        o_cs_n = 1'b0;
        #7.5;
        for (int i = 0; i < nbits; i++) begin
            o_din = tx[nbits-1-i];
            #7.5 o_sclk = 1'b0;
            // Released line shows no stale level: inverse of the last bit
            seen = i_dout_oe ? i_dout : ~last_bit;
            last_bit = seen;
            rx = {rx[46:0], seen};
            #7.5 o_sclk = 1'b1;
        end
        #7.5 o_cs_n = 1'b1;
        o_din = ~o_din;
        #30;
    endtask
endmodule

/* File: meter_serial_port_pins_bench.sv */
// Self-checking bench of the meter serial port pins block
module meter_serial_port_pins_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import msp_pkg::*;

    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_sclk, i_cs_n, i_din, o_dout, o_dout_oe, o_irq_n_out, o_irq_n_oe;
    msp_rx_t o_rx_word;
    logic o_rx_valid, o_tx_ready, o_rx_overrun, o_tx_underrun, o_frame_active;
    logic i_rx_ready = 1'b0;
    logic [7:0] i_tx_data = 8'h00;
    logic i_tx_valid = 1'b0;
    msp_irq_t i_irq_event = 4'h0;
    msp_irq_t i_irq_enable = 4'h0;
    msp_irq_t i_irq_clear = 4'h0;
    msp_irq_t o_irq_status;
    logic irq_line;
    logic oe_seen = 1'b0;
    logic [47:0] rx;
    int err_count = 0;
    int check_count = 0;

    // Core clock, 5 ns
    always #2.5 i_clk = ~i_clk;
    // Interrupt wire with pull-up
    assign irq_line = o_irq_n_oe ? o_irq_n_out : 1'b1;
    // Remembers any drive of the data output
    always @(posedge o_dout_oe) oe_seen = 1'b1;

    msp_top msp_top_inst (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
        .i_din(i_din), .o_dout(o_dout), .o_dout_oe(o_dout_oe),
        .o_irq_n_out(o_irq_n_out), .o_irq_n_oe(o_irq_n_oe), .o_rx_word(o_rx_word),
        .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready), .i_tx_data(i_tx_data),
        .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready), .i_irq_event(i_irq_event),
        .i_irq_enable(i_irq_enable), .i_irq_clear(i_irq_clear),
        .o_irq_status(o_irq_status), .o_rx_overrun(o_rx_overrun),
        .o_tx_underrun(o_tx_underrun), .o_frame_active(o_frame_active)
    );

    msp_host_model msp_host_model_inst (
        .i_dout(o_dout), .i_dout_oe(o_dout_oe), .o_sclk(i_sclk), .o_cs_n(i_cs_n),
        .o_din(i_din)
    );

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Waits for a received word, compares it and pops it
    task automatic pop(input logic [8:0] exp);
        @(negedge i_clk);
        for (int i = 0; i < 50 && o_rx_valid !== 1'b1; i++) @(negedge i_clk);
        check("rx_valid", o_rx_valid, 1'b1);
        check("rx_word", o_rx_word, exp);
        i_rx_ready = 1'b1;
        @(negedge i_clk);
        i_rx_ready = 1'b0;
    endtask

    // Hands one byte to the holding word
    task automatic load(input logic [7:0] d);
        @(negedge i_clk);
        i_tx_data = d;
        i_tx_valid = 1'b1;
        @(negedge i_clk);
        i_tx_valid = 1'b0;
        check("tx_ready", o_tx_ready, 1'b0);
    endtask

    // Sets one interrupt source, looks at the pin, then clears it
    task automatic irq_case(input int idx, input msp_irq_t en, input logic req);
        @(negedge i_clk);
        i_irq_enable = en;
        i_irq_event = 4'h1 << idx;
        @(negedge i_clk);
        i_irq_event = 4'h0;
        check("status", o_irq_status[idx], 1'b1);
        check("irq_line", irq_line, !req);
        i_irq_clear = 4'h1 << idx;
        @(negedge i_clk);
        i_irq_clear = 4'h0;
        check("status_clr", o_irq_status, 4'h0);
        check("irq_idle", irq_line, 1'b1);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic write_frame();
        oe_seen = 1'b0;
        msp_host_model_inst.frame({32'h0, 8'h9a, 8'h5c}, 16, rx);
        check("oe_write", oe_seen, 1'b0);
        pop({1'b1, 8'h9a});
        pop({1'b0, 8'h5c});
        check("frame_active", o_frame_active, 1'b0);
    endtask

    task automatic abort_frame();
        msp_host_model_inst.frame({43'h0, 5'h15}, 5, rx);
        msp_host_model_inst.frame({32'h0, 8'h8c, 8'h3e}, 16, rx);
        pop({1'b1, 8'h8c});
        pop({1'b0, 8'h3e});
        repeat (8) @(negedge i_clk);
        check("rx_empty", o_rx_valid, 1'b0);
    endtask

    task automatic read_frames();
        load(8'ha5);
        oe_seen = 1'b0;
        msp_host_model_inst.frame({32'h0, 8'h3c, 8'h69}, 16, rx);
        check("read_data", rx[7:0], 8'ha5);
        check("oe_read", oe_seen, 1'b1);
        check("oe_off", o_dout_oe, 1'b0);
        pop({1'b1, 8'h3c});
        pop({1'b0, 8'h69});
        check("tx_ready", o_tx_ready, 1'b1);
        check("underrun0", o_tx_underrun, 1'b0);
        msp_host_model_inst.frame({32'h0, 8'h01, 8'h00}, 16, rx);
        check("stale_data", rx[7:0], 8'ha5);
        check("underrun1", o_tx_underrun, 1'b1);
        pop({1'b1, 8'h01});
        pop({1'b0, 8'h00});
    endtask

    task automatic fill_fifo();
        msp_host_model_inst.frame(48'h81_11_22_33_44_55, 48, rx);
        repeat (8) @(negedge i_clk);
        check("overrun", o_rx_overrun, 1'b1);
        pop({1'b1, 8'h81});
        pop({1'b0, 8'h11});
        pop({1'b0, 8'h22});
        pop({1'b0, 8'h33});
        pop({1'b0, 8'h44});
        repeat (8) @(negedge i_clk);
        check("drained", o_rx_valid, 1'b0);
    endtask

    task automatic reset_mid_run();
        load(8'h77);
        i_irq_enable = 4'hf;
        i_irq_event = 4'h1;
        @(negedge i_clk);
        i_irq_clear = 4'h1; // Event still high: the set must win
        @(negedge i_clk);
        check("set_wins", o_irq_status[0], 1'b1);
        i_irq_event = 4'h0;
        i_irq_clear = 4'h0;
        @(negedge i_clk);
        i_reset_n = 1'b0;
        repeat (10) @(negedge i_clk);
        check("rst_status", o_irq_status, 4'h0);
        check("rst_irq", irq_line, 1'b1);
        check("rst_tx_ready", o_tx_ready, 1'b1);
        check("rst_overrun", o_rx_overrun, 1'b0);
        check("rst_underrun", o_tx_underrun, 1'b0);
        check("rst_oe", o_dout_oe, 1'b0);
        i_reset_n = 1'b1;
        repeat (2) @(negedge i_clk);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(negedge i_clk);
        i_reset_n = 1'b1;
        repeat (2) @(negedge i_clk);
        check("idle_rx", o_rx_valid, 1'b0);
        check("idle_oe", o_dout_oe, 1'b0);
        write_frame();
        abort_frame();
        read_frames();
        fill_fifo();
        for (int i = 0; i < 3; i++) begin
            irq_case(i, 4'hf, 1'b1);
            irq_case(i, 4'h0, 1'b0);
        end
        irq_case(3, 4'hf, 1'b0);
        reset_mid_run();
        report_and_stop();
    end

    // Cuts a hang short well beyond the expected run time
    initial begin
        #50000;
        err_count++;
        report_and_stop();
    end
endmodule
